// *** rtl/wsw_pkg.sv ***
// constants and types for the watchdog, sleep and wake-up controller
`default_nettype none
package wsw_pkg;

	// control register field layout
	localparam int unsigned CTRL_CS_BIT  = 7;
	localparam int unsigned CTRL_PS_MSB  = 5;
	localparam int unsigned CTRL_PS_LSB  = 1;
	localparam int unsigned CTRL_SEN_BIT = 0;

	// prescale: ratio is 1:32 shifted left by the code
	localparam logic [4:0]  PS_RESET   = 5'h0b;
	localparam logic [4:0]  PS_MAX     = 5'h12;
	localparam logic [4:0]  PS_MIN     = 5'h00;
	localparam logic [4:0]  BASE_SHIFT = 5'h05;
	localparam int unsigned CNT_W      = 24;

	// watchdog mode configuration codes
	localparam logic [1:0] MODE_ON    = 2'h3;
	localparam logic [1:0] MODE_AWAKE = 2'h2;
	localparam logic [1:0] MODE_SOFT  = 2'h1;
	localparam logic [1:0] MODE_OFF   = 2'h0;

	typedef enum logic [1:0] {
		ST_AWAKE,
		ST_ASLEEP,
		ST_RESUME
	} wsw_state_t;

	// whole state of the controller
	typedef struct packed {
		wsw_state_t        state;
		logic [1:0]        lf_s;
		logic              lf_d;
		logic [1:0]        mf_s;
		logic              mf_d;
		logic [2:0]        rs_s1;
		logic [2:0]        rs_s2;
		logic              cs;
		logic [4:0]        ps;
		logic              soft_watchdog_enable;
		logic [CNT_W-1:0]  count;
		logic              pd_n;
		logic              to_n;
		logic              watchdog_reset_flag_n_n;
		logic              wake_irq;
		logic              wake_pulse;
		logic              vec_pulse;
		logic              abort_pulse;
		logic              prefetch_pulse;
		logic              wdt_rst_pulse;
		logic              sys_rst_req;
	} wsw_regs_t;

	localparam wsw_regs_t REGS_RST = '{
		state:  ST_AWAKE,
		ps:     PS_RESET,
		pd_n:   1'b1,
		to_n:   1'b1,
		watchdog_reset_flag_n_n: 1'b1,
		default: '0
	};

endpackage

`default_nettype wire

// *** rtl/wsw_ctrl.sv ***
// watchdog timer with sleep entry and wake-up control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RL1: sleep entry clears watchdog, clears power-down bit, sets time-out bit
// RL2: processor and system clocks stop while asleep
// RL3: oscillators stay on in sleep when requested or forced on
// RL4: sleep aborts conversion, converter off unless on own oscillator
// RL5: idle ports hold their prior state during sleep
// RL6: reset pins reset the device; watchdog or interrupt resumes execution
// RL7: sleep instruction prefetches the next instruction
// RL8: only enabled interrupts wake, regardless of global interrupt enable
// RL9: after interrupt wake run next instruction, then vector if enabled
// RL10: pending enabled interrupt makes sleep a no-operation, nothing changes
// RL11: interrupt during sleep entry completes sleep then wakes at once
// RL12: watchdog is cleared on every wake-up
// RL13: firmware must clear watchdog in time or a reset results
// RL14: clock-select bit picks medium or low frequency oscillator
// RL15: mode 11 keeps watchdog active awake and asleep
// RL16: mode 10 keeps watchdog active only while awake
// RL17: mode 01 lets the software enable bit decide
// RL18: mode 00 disables the watchdog entirely
// RL19: prescale sets time-out, defaulting to two seconds after reset
// RL20: watchdog cleared on reset, clear instr, sleep, wake, control write
// RL21: time-out in sleep wakes without reset, clears three status bits
// RL22: ratio is 1:32 times two to the code; reserved codes give 1:32
// RL23: control holds clock select bit 7, prescale 5:1, enable bit 0
// RL24: prescaler and time-out share one counter on oscillator ticks
module wsw_ctrl #(
	parameter int unsigned N_IRQ  = 8,
	parameter int unsigned N_PORT = 4
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// configuration
	input  wire logic [1:0]        watchdog_mode_config,
	// control register strobe
	input  wire logic              ctrl_wr,
	input  wire logic [7:0]        ctrl_wdata,
	output logic      [7:0]        ctrl_rdata,
	// processor core
	input  wire logic              sleep_instr,
	input  wire logic              clear_watchdog_instr,
	input  wire logic              instr_retire,
	input  wire logic              global_interrupt_enable,
	output logic                   cpu_clk_en,
	output logic                   sys_clk_en,
	output logic                   prefetch_next,
	output logic                   wake_pulse,
	output logic                   irq_vector_req,
	// interrupt sources
	input  wire logic [N_IRQ-1:0]  irq_flags,
	input  wire logic [N_IRQ-1:0]  irq_enables,
	// reset sources, asynchronous pins
	input  wire logic              master_clear_pin,
	input  wire logic              brownout_reset,
	input  wire logic              power_on_reset,
	output logic                   system_reset_req,
	output logic                   watchdog_reset_req,
	// status bits, active low
	output logic                   power_down_status_n,
	output logic                   time_out_status_n,
	output logic                   watchdog_reset_flag_n,
	// oscillators
	input  wire logic              low_freq_osc,
	input  wire logic              medium_freq_osc,
	input  wire logic              periph_lf_req,
	input  wire logic              periph_hf_req,
	input  wire logic              low_osc_force_on,
	input  wire logic              medium_osc_force_on,
	input  wire logic              high_osc_force_on,
	output logic                   lf_osc_en,
	output logic                   mf_osc_en,
	output logic                   hf_osc_en,
	// converter
	input  wire logic              converter_own_osc,
	input  wire logic              converter_on_bit,
	input  wire logic              conv_busy,
	output logic                   conv_run_en,
	output logic                   conv_abort,
	// i/o ports
	input  wire logic [N_PORT-1:0] port_periph_active,
	output logic      [N_PORT-1:0] port_hold
);

	localparam int unsigned CW = wsw_pkg::CNT_W;

	wsw_pkg::wsw_regs_t q;
	wsw_pkg::wsw_regs_t nxt_q;

	logic          awake;
	logic          asleep;
	logic          pending;
	logic          wdt_active;
	logic          tick;
	logic [4:0]    ps_eff;
	logic [CW-1:0] limit;
	logic          timeout;

	// status decode shared by the update logic and the outputs
	assign awake   = (q.state != wsw_pkg::ST_ASLEEP);
	assign asleep  = (q.state == wsw_pkg::ST_ASLEEP);
	assign pending = |(irq_flags & irq_enables); // [RL8]

	// mode decode; all four codes are decoded, mode 00 gives disabled
	always_comb begin
		unique case (watchdog_mode_config)
			wsw_pkg::MODE_ON:    wdt_active = 1'b1;          // [RL15]
			wsw_pkg::MODE_AWAKE: wdt_active = awake;         // [RL16]
			wsw_pkg::MODE_SOFT:  wdt_active = q.soft_watchdog_enable;         // [RL17]
			wsw_pkg::MODE_OFF:   wdt_active = 1'b0;          // [RL18]
		endcase
	end

	// one oscillator edge per tick; second flop feeds the edge detector
	assign tick = q.cs ? (q.mf_s[1] & ~q.mf_d)
		: (q.lf_s[1] & ~q.lf_d); // [RL14] [RL24]

	// reserved prescale codes fall back to the shortest interval
	assign ps_eff = (q.ps > wsw_pkg::PS_MAX) ? wsw_pkg::PS_MIN : q.ps; // [RL22]
	assign limit  = (CW'(1) << (ps_eff + wsw_pkg::BASE_SHIFT))
		- CW'(1); // [RL22]
	assign timeout = wdt_active & tick & (q.count == limit); // [RL19]

	// next-state logic for the whole controller
	always_comb begin
		nxt_q = q;
		nxt_q.wake_pulse     = 1'b0;
		nxt_q.vec_pulse      = 1'b0;
		nxt_q.abort_pulse    = 1'b0;
		nxt_q.prefetch_pulse = 1'b0;
		nxt_q.wdt_rst_pulse  = 1'b0;
		// pin and oscillator synchronisers
		nxt_q.lf_s  = {q.lf_s[0], low_freq_osc};
		nxt_q.lf_d  = q.lf_s[1];
		nxt_q.mf_s  = {q.mf_s[0], medium_freq_osc};
		nxt_q.mf_d  = q.mf_s[1];
		nxt_q.rs_s1 = {master_clear_pin, brownout_reset, power_on_reset};
		nxt_q.rs_s2 = q.rs_s1;
		nxt_q.sys_rst_req = |q.rs_s2; // [RL6]

		// count on ticks only; clears below take priority
		if (!wdt_active) begin
			nxt_q.count = '0;
		end else if (tick) begin
			nxt_q.count = timeout ? '0 : q.count + CW'(1); // [RL24]
		end

		// control write reloads fields and restarts the count
		if (ctrl_wr) begin
			nxt_q.cs    = ctrl_wdata[wsw_pkg::CTRL_CS_BIT]; // [RL23]
			nxt_q.ps    = ctrl_wdata[wsw_pkg::CTRL_PS_MSB:
				wsw_pkg::CTRL_PS_LSB]; // [RL23]
			nxt_q.soft_watchdog_enable   = ctrl_wdata[wsw_pkg::CTRL_SEN_BIT]; // [RL23]
			nxt_q.count = '0; // [RL20]
		end
		if (clear_watchdog_instr && awake) begin
			nxt_q.count = '0; // [RL20] [RL13]
		end

		unique case (q.state)
			wsw_pkg::ST_AWAKE: begin
				if (timeout) begin
					// firmware missed its clear: reset event
					nxt_q.wdt_rst_pulse = 1'b1; // [RL13]
					nxt_q.watchdog_reset_flag_n_n        = 1'b0;
					nxt_q.to_n          = 1'b0;
				end else if (sleep_instr) begin
					nxt_q.prefetch_pulse = 1'b1; // [RL7]
					if (!pending) begin
						nxt_q.state = wsw_pkg::ST_ASLEEP;
						nxt_q.count = '0;   // [RL1] [RL20]
						nxt_q.pd_n  = 1'b0; // [RL1]
						nxt_q.to_n  = 1'b1; // [RL1]
						nxt_q.abort_pulse = conv_busy
							& ~converter_own_osc; // [RL4]
					end
					// pending interrupt: sleep acts as a no-op [RL10]
				end
			end
			wsw_pkg::ST_ASLEEP: begin
				// interrupt wins over a same-cycle time-out
				if (pending) begin
					nxt_q.state      = wsw_pkg::ST_RESUME; // [RL11]
					nxt_q.wake_irq   = 1'b1;
					nxt_q.wake_pulse = 1'b1; // [RL6]
					nxt_q.count      = '0;   // [RL12]
				end else if (timeout) begin
					nxt_q.state      = wsw_pkg::ST_RESUME; // [RL21]
					nxt_q.wake_irq   = 1'b0;
					nxt_q.wake_pulse = 1'b1;
					nxt_q.count      = '0;   // [RL12]
					nxt_q.to_n       = 1'b0; // [RL21]
					nxt_q.pd_n       = 1'b0; // [RL21]
					nxt_q.watchdog_reset_flag_n_n     = 1'b0; // [RL21]
				end
			end
			wsw_pkg::ST_RESUME: begin
				// the instruction after sleep runs before any vectoring
				if (instr_retire) begin
					nxt_q.state     = wsw_pkg::ST_AWAKE;
					nxt_q.vec_pulse = q.wake_irq
						& global_interrupt_enable; // [RL9]
					nxt_q.wake_irq  = 1'b0;
				end
			end
			default: nxt_q.state = wsw_pkg::ST_AWAKE;
		endcase
	end

	// single register bank; the reset input restores defaults and clears count
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q <= wsw_pkg::REGS_RST; // [RL19] [RL20]
		end else begin
			q <= nxt_q;
		end
	end

	// register read-back and status
	assign ctrl_rdata = {q.cs, 1'b0, q.ps, q.soft_watchdog_enable}; // [RL23]
	assign power_down_status_n   = q.pd_n;
	assign time_out_status_n     = q.to_n;
	assign watchdog_reset_flag_n = q.watchdog_reset_flag_n_n;
	assign system_reset_req      = q.sys_rst_req;
	assign watchdog_reset_req    = q.wdt_rst_pulse;
	assign prefetch_next         = q.prefetch_pulse;
	assign wake_pulse            = q.wake_pulse;
	assign irq_vector_req        = q.vec_pulse;
	assign conv_abort            = q.abort_pulse;

	// clock gating: stopping the core clock is what saves the power
	assign cpu_clk_en = awake; // [RL2]
	assign sys_clk_en = awake; // [RL2]

	// oscillators also kept alive when the watchdog counts on them in sleep
	assign lf_osc_en = awake | periph_lf_req | low_osc_force_on
		| (wdt_active & ~q.cs); // [RL3]
	assign mf_osc_en = awake | medium_osc_force_on
		| (wdt_active & q.cs); // [RL3]
	assign hf_osc_en = awake | periph_hf_req | high_osc_force_on; // [RL3]

	// converter powers down in sleep unless on its own oscillator; its on-bit is left untouched
	assign conv_run_en = converter_on_bit
		& (awake | converter_own_osc); // [RL4]

	// per-port hold while asleep
	genvar gi;
	generate
		for (gi = 0; gi < N_PORT; gi++) begin : g_port
			assign port_hold[gi] = asleep & ~port_periph_active[gi]; // [RL5]
		end
	endgenerate

	// checks
	sleep_entry_a: assert property (@(posedge mclk) disable iff (reset) // [RL1]
		(q.state == wsw_pkg::ST_AWAKE && sleep_instr && !pending
			&& !timeout)
		|=> (asleep && !power_down_status_n && time_out_status_n
			&& q.count == '0))
		else $error("sleep entry did not clear count and set status");

	clock_gate_a: assert property (@(posedge mclk) disable iff (reset) // [RL2]
		asleep |-> (!cpu_clk_en && !sys_clk_en))
		else $error("core clock running while asleep");

	osc_keep_a: assert property (@(posedge mclk) disable iff (reset) // [RL3]
		(low_osc_force_on || periph_lf_req) |-> lf_osc_en)
		else $error("low oscillator stopped while requested");

	conv_abort_a: assert property (@(posedge mclk) disable iff (reset) // [RL4]
		(q.state == wsw_pkg::ST_AWAKE && sleep_instr && !pending
			&& !timeout && conv_busy && !converter_own_osc)
		|=> conv_abort ##1 !conv_abort)
		else $error("conversion not aborted on sleep entry");

	port_hold_a: assert property (@(posedge mclk) disable iff (reset) // [RL5]
		port_hold == ({N_PORT{asleep}} & ~port_periph_active))
		else $error("port hold mismatch");

	nop_sleep_a: assert property (@(posedge mclk) disable iff (reset) // [RL10]
		(q.state == wsw_pkg::ST_AWAKE && sleep_instr && pending
			&& !timeout && !ctrl_wr)
		|=> (awake && $stable(power_down_status_n)
			&& $stable(time_out_status_n) && prefetch_next))
		else $error("sleep with pending interrupt changed state");

	irq_wake_a: assert property (@(posedge mclk) disable iff (reset) // [RL11]
		(asleep && pending)
		|=> (wake_pulse && q.state == wsw_pkg::ST_RESUME
			&& q.count == '0 && cpu_clk_en))
		else $error("enabled interrupt did not wake at once");

	vector_a: assert property (@(posedge mclk) disable iff (reset) // [RL9]
		(q.state == wsw_pkg::ST_RESUME && instr_retire && q.wake_irq)
		|=> (irq_vector_req == $past(global_interrupt_enable)))
		else $error("vectoring after wake disagrees with enable");

	wdt_reset_a: assert property (@(posedge mclk) disable iff (reset) // [RL13]
		(q.state == wsw_pkg::ST_AWAKE && timeout)
		|=> (watchdog_reset_req && !watchdog_reset_flag_n)
			##1 !watchdog_reset_req)
		else $error("awake time-out did not raise one reset pulse");

	sleep_tmo_a: assert property (@(posedge mclk) disable iff (reset) // [RL21]
		(asleep && timeout && !pending)
		|=> (!watchdog_reset_req && wake_pulse && !time_out_status_n
			&& !power_down_status_n && !watchdog_reset_flag_n))
		else $error("sleep time-out handled wrongly");

	mode_off_a: assert property (@(posedge mclk) disable iff (reset) // [RL18]
		(watchdog_mode_config == wsw_pkg::MODE_OFF) ##1
			(watchdog_mode_config == wsw_pkg::MODE_OFF)
		|-> q.count == '0)
		else $error("watchdog counting while disabled");

	ctrl_write_a: assert property (@(posedge mclk) disable iff (reset) // [RL20]
		ctrl_wr |=> (q.count == '0 && ctrl_rdata ==
			{$past(ctrl_wdata[7]), 1'b0, $past(ctrl_wdata[5:0])}))
		else $error("control write did not load and clear");

	next_fetch_a: assert property (@(posedge mclk) disable iff (reset) // [RL7]
		(q.state == wsw_pkg::ST_AWAKE && sleep_instr && !timeout)
		|=> prefetch_next)
		else $error("sleep instruction did not prefetch");

	pin_reset_a: assert property (@(posedge mclk) disable iff (reset) // [RL6]
		(master_clear_pin || brownout_reset || power_on_reset)
		|-> ##3 system_reset_req)
		else $error("reset pin did not raise a system reset");

	wake_clear_a: assert property (@(posedge mclk) disable iff (reset) // [RL12]
		wake_pulse |-> (q.count == '0 && awake))
		else $error("watchdog not cleared on wake-up");

	sleep_cov: cover property (@(posedge mclk) disable iff (reset)
		asleep ##1 wake_pulse);
	tmo_wake_cov: cover property (@(posedge mclk) disable iff (reset)
		asleep && timeout);
	vector_cov: cover property (@(posedge mclk) disable iff (reset)
		irq_vector_req);
	nop_cov: cover property (@(posedge mclk) disable iff (reset)
		awake && sleep_instr && pending);

endmodule

`default_nettype wire

// *** dv/wsw_core_model.sv ***
// processor core model: issues sleep, watchdog clears and retirements
`timescale 1ns/1ps
`default_nettype none
module wsw_core_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// bench requests
	input  wire logic       do_sleep,
	input  wire logic [7:0] clr_gap,
	input  wire logic [3:0] retire_dly,
	// controller side
	input  wire logic       cpu_clk_en,
	input  wire logic       wake_pulse,
	output logic            sleep_instr,
	output logic            clear_watchdog_instr,
	output logic            instr_retire
);
	logic [7:0] gap_cnt;
	logic [4:0] ret_cnt;

	// core acts only while its clock runs; retire lags wake by a chosen delay
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sleep_instr          <= 1'b0;
			clear_watchdog_instr <= 1'b0;
			instr_retire         <= 1'b0;
			gap_cnt              <= 8'h00;
			ret_cnt              <= 5'h00;
		end else begin
			sleep_instr          <= do_sleep & cpu_clk_en;
			clear_watchdog_instr <= 1'b0;
			if (clr_gap == 8'h00 || !cpu_clk_en) begin
				gap_cnt <= 8'h00;
			end else if (gap_cnt >= clr_gap) begin
				clear_watchdog_instr <= 1'b1;
				gap_cnt              <= 8'h00;
			end else begin
				gap_cnt <= gap_cnt + 8'h01;
			end
			instr_retire <= (ret_cnt == 5'h01);
			if (wake_pulse) begin
				ret_cnt <= {1'b0, retire_dly} + 5'h02;
			end else if (ret_cnt != 5'h00) begin
				ret_cnt <= ret_cnt - 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the watchdog, sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
	logic       mclk, reset, ctrl_wr, sleep_instr, clear_watchdog_instr;
	logic       instr_retire, global_interrupt_enable, cpu_clk_en, sys_clk_en;
	logic       prefetch_next, wake_pulse, irq_vector_req, master_clear_pin;
	logic       brownout_reset, power_on_reset, system_reset_req;
	logic       watchdog_reset_req, power_down_status_n, time_out_status_n;
	logic       watchdog_reset_flag_n, low_freq_osc, medium_freq_osc;
	logic       periph_lf_req, periph_hf_req, low_osc_force_on, lf_osc_en;
	logic       medium_osc_force_on, high_osc_force_on, mf_osc_en, hf_osc_en;
	logic       converter_own_osc, converter_on_bit, conv_busy, conv_run_en;
	logic       conv_abort, do_sleep, seen, seen2;
	logic [1:0] watchdog_mode_config;
	logic [7:0] ctrl_wdata, ctrl_rdata, irq_flags, irq_enables, clr_gap, d;
	logic [3:0] port_periph_active, port_hold, rdly;
	logic [5:0] tbl [5];
	int         err_total, n_tests, n, i;
	logic [2:0] st3;

	// status bits gathered as pd, to, watchdog_reset_flag_n for short compares
	assign st3 = {power_down_status_n, time_out_status_n,
		watchdog_reset_flag_n};

	wsw_ctrl DUT (.mclk, .reset, .watchdog_mode_config, .ctrl_wr, .ctrl_wdata,
		.ctrl_rdata, .sleep_instr, .clear_watchdog_instr, .instr_retire,
		.global_interrupt_enable, .cpu_clk_en, .sys_clk_en, .prefetch_next,
		.wake_pulse, .irq_vector_req, .irq_flags, .irq_enables,
		.master_clear_pin, .brownout_reset, .power_on_reset, .system_reset_req,
		.watchdog_reset_req, .power_down_status_n, .time_out_status_n,
		.watchdog_reset_flag_n, .low_freq_osc, .medium_freq_osc,
		.periph_lf_req, .periph_hf_req, .low_osc_force_on, .medium_osc_force_on,
		.high_osc_force_on, .lf_osc_en, .mf_osc_en, .hf_osc_en,
		.converter_own_osc, .converter_on_bit, .conv_busy, .conv_run_en,
		.conv_abort, .port_periph_active, .port_hold);
	wsw_core_model core (.mclk, .reset, .do_sleep, .clr_gap,
		.retire_dly(rdly), .cpu_clk_en, .wake_pulse, .sleep_instr,
		.clear_watchdog_instr, .instr_retire);

	// system clock and two free-running oscillators, 8 and 16 mclk periods
	initial begin mclk = 0; forever #2.5 mclk = ~mclk; end
	initial begin
		low_freq_osc = 0;
		forever #20 low_freq_osc = ~low_freq_osc;
	end
	initial begin
		medium_freq_osc = 0;
		forever #40 medium_freq_osc = ~medium_freq_osc;
	end

	// expected time-out in mclk cycles; reserved codes fall back to 1:32
	function automatic int exp_cyc(input logic cs, input logic [4:0] ps);
		logic [4:0] e;
		e = (ps > 5'h12) ? 5'h00 : ps;
		return (32 << e) * (cs ? 16 : 8);
	endfunction
	function automatic logic wdt_on(input logic [1:0] m, input logic s);
		return m == 2'h3 || m == 2'h2 || (m == 2'h1 && s);
	endfunction

	task automatic cyc(input int k); repeat (k) @(posedge mclk); #1; endtask
	task automatic do_reset; reset = 1; cyc(4); reset = 0; endtask
	task automatic wr(input logic [7:0] v);
		ctrl_wdata = v; ctrl_wr = 1; cyc(1); ctrl_wr = 0;
	endtask
	task automatic sleep_go; do_sleep = 1; cyc(1); do_sleep = 0; cyc(1); endtask
	// bounded wait for a watchdog reset request, cycles returned in m
	task automatic wait_wdt(input int lim, output int m);
		m = 0;
		while (watchdog_reset_req !== 1'b1 && m < lim) begin cyc(1); m++; end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hang guard, far beyond the few thousand cycles the tests need
	initial begin #250000; err_total++; give_verdict; end

	initial begin
		{reset, ctrl_wr, do_sleep, global_interrupt_enable} = 4'h0;
		{master_clear_pin, brownout_reset, power_on_reset} = 3'h0;
		{periph_lf_req, periph_hf_req, low_osc_force_on} = 3'h0;
		{medium_osc_force_on, high_osc_force_on, converter_own_osc} = 3'h0;
		{converter_on_bit, conv_busy} = 2'h0;
		{ctrl_wdata, irq_flags, irq_enables, clr_gap} = 32'h0;
		{watchdog_mode_config, port_periph_active, rdly} = 10'h0;
		tbl = '{6'h00, 6'h01, 6'h1f, 6'h13, 6'h20};
		err_total = 0; n_tests = 0; i = $urandom(22);
		do_reset;
		`CHK("ctrl_rst", 8'h16, ctrl_rdata)
		`CHK("status_rst", 3'h7, st3)
		repeat (4) begin
			d = $urandom; wr(d);
			`CHK("ctrl_rdata", {d[7], 1'b0, d[5:0]}, ctrl_rdata)
			cyc(1);
		end
		for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) begin
			watchdog_mode_config = m[1:0]; wr({7'h00, s[0]}); wait_wdt(320, n);
			seen = wdt_on(m[1:0], s[0]);
			`CHK("wdt_mode", seen, watchdog_reset_req)
		end
		watchdog_mode_config = 2'h3;
		foreach (tbl[k]) begin
			wr({tbl[k][5], 1'b0, tbl[k][4:0], 1'b0}); wait_wdt(1200, n);
			i = exp_cyc(tbl[k][5], tbl[k][4:0]);
			`CHK("wdt_period", 1'b1, n >= i - 20 && n <= i + 20)
		end
		wr(8'h00); clr_gap = 8'd40 + 8'($urandom % 160); wait_wdt(700, n);
		`CHK("wdt_cleared", 1'b0, watchdog_reset_req)
		clr_gap = 0; watchdog_mode_config = 2'h0; do_reset;
		irq_flags = 8'h04; irq_enables = 8'h04; sleep_go;
		`CHK("prefetch", 1'b1, prefetch_next)
		`CHK("sleep_nop", 2'h3, {power_down_status_n, cpu_clk_en})
		irq_flags = 0; cyc(2);
		for (int g = 0; g < 2; g++) begin
			port_periph_active = 4'($urandom);
			periph_hf_req = 1'($urandom);
			high_osc_force_on = 1'($urandom);
			periph_lf_req = 1'($urandom);
			low_osc_force_on = 1'($urandom);
			medium_osc_force_on = 1'($urandom);
			{converter_on_bit, conv_busy} = 2'h3;
			converter_own_osc = g[0];
			sleep_go;
			`CHK("conv_abort", !g[0], conv_abort)
			`CHK("conv_run", g[0], conv_run_en)
			`CHK("sleep_status", 2'h1, st3[2:1])
			`CHK("clk_en", 2'h0, {cpu_clk_en, sys_clk_en})
			`CHK("port_hold", ~port_periph_active, port_hold)
			`CHK("hf_en", periph_hf_req | high_osc_force_on, hf_osc_en)
			`CHK("lf_en", periph_lf_req | low_osc_force_on, lf_osc_en)
			`CHK("mf_en", medium_osc_force_on, mf_osc_en)
			conv_busy = 0; irq_flags = 8'h10; irq_enables = 8'h00; cyc(10);
			`CHK("masked_irq", 1'b0, cpu_clk_en)
			irq_enables = 8'h10; global_interrupt_enable = g[0];
			rdly = 4'($urandom % 8); {seen, seen2} = 2'h0;
			for (i = 0; i < 20; i++) begin
				cyc(1); seen |= wake_pulse; seen2 |= irq_vector_req;
				if (seen) irq_flags = 8'h00;
			end
			`CHK("irq_wake", 1'b1, seen)
			`CHK("irq_vector", g[0], seen2)
			`CHK("wake_to", 1'b1, time_out_status_n)
			irq_enables = 0;
		end
		for (int m = 3; m > 1; m--) begin
			watchdog_mode_config = m[1:0];
			{periph_lf_req, low_osc_force_on} = 2'h0;
			do_reset; wr(8'h00); sleep_go;
			`CHK("lf_wdt", m == 3, lf_osc_en)
			{seen, seen2} = 2'h0;
			for (i = 0; i < 400 && !seen; i++) begin
				cyc(1); seen |= wake_pulse; seen2 |= watchdog_reset_req;
			end
			`CHK("wdt_wake", m == 3, seen)
			`CHK("no_reset", 1'b0, seen2)
			if (m == 3) `CHK("wake_flags", 3'h0, st3)
		end
		irq_flags = 8'h01; irq_enables = 8'h01; cyc(5); irq_flags = 0; cyc(5);
		for (int k = 0; k < 3; k++) begin
			{power_on_reset, brownout_reset, master_clear_pin} = 3'h1 << k; cyc(4);
			`CHK("sys_rst", 1'b1, system_reset_req)
			{power_on_reset, brownout_reset, master_clear_pin} = 3'h0; cyc(4);
			`CHK("sys_rst_off", 1'b0, system_reset_req)
		end
		give_verdict;
	end
endmodule
`default_nettype wire
